// ===== hdl/fsq_host.sv
`timescale 1ns/1ps
`include "fsq_regs.svh"
// How it works
// - program: AA/555, 55/2AA, A0/555, then data to target
// - sector erase: unlock, 80/555, unlock, 30 to sector address
// - block erase: as sector erase but final code 50 to block address
// - chip erase: six writes, final 10 to 555
// - one write of B0 anywhere suspends erase
// - one write of 30 anywhere resumes erase
// - unlock then 88/555 enters security-identifier query mode
// - user identifier program: unlock, A5/555, data to words 10..17
// - host completes all four cycles before expecting array read
// - lock-out: unlock, 85/555, 0000 anywhere, in word mode
// - identification entry: unlock, 90 to bank with lines 19,18 low
// - CFI entry: unlock, 98 to bank, then table reads
// - unlock then F0/555 exits every special read mode
module fsq_host import fsq_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire fsq_req_s i_req,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output logic [15:0] o_rdata,
    output fsq_mode_e o_mode,
    input wire logic [15:0] i_dq,
    output fsq_pins_s o_pins
);
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} fsq_hst_e;
    fsq_hst_e st_q, st_d;
    fsq_req_s req_q, req_d;
    logic [2:0] step_q, step_d;
    fsq_mode_e mode_q, mode_d;
    logic rsp_q, rsp_d;
    logic err_q, err_d;
    logic [15:0] rdata_q, rdata_d;
    fsq_cyc_s cyc;
    logic is_data;
    logic [2:0] nsteps;
    logic start;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic uid_bad;
    logic last;

    // number of bus cycles per operation
    always_comb begin
        case (req_q.op)
            FSQ_OP_READ, FSQ_OP_SUSP, FSQ_OP_RES: nsteps = 3'd1;
            FSQ_OP_PROG, FSQ_OP_UIDP, FSQ_OP_LOCK: nsteps = 3'd4;
            FSQ_OP_SECT, FSQ_OP_BLK, FSQ_OP_CHIP: nsteps = 3'd6;
            default: nsteps = 3'd3;
        endcase
    end

    // address and data of the current bus cycle
    always_comb begin
        cyc = '0;
        is_data = 1'b0;
        // upper data byte driven low during commands
        cyc.byte_n = !req_q.byte_mode;
        if (req_q.op == FSQ_OP_LOCK) begin
            cyc.byte_n = 1'b1;
        end
        cyc.addr = {9'h000, `FSQ_A_UNL1};
        case (req_q.op)
            FSQ_OP_READ: begin
                // query and table reads use the caller address
                cyc.rd = 1'b1;
                cyc.addr = req_q.addr;
                cyc.addr_lsb = req_q.addr_lsb;
                is_data = 1'b1;
            end
            FSQ_OP_SUSP: begin
                cyc.addr = req_q.addr;
                cyc.data = {8'h00, `FSQ_D_SUSP};
            end
            FSQ_OP_RES: begin
                cyc.addr = req_q.addr;
                cyc.data = {8'h00, `FSQ_D_RES};
            end
            default: begin
                case (step_q)
                    3'd0: begin
                        cyc.data = {8'h00, `FSQ_D_UNL1};
                    end
                    3'd1: begin
                        cyc.addr = {9'h000, `FSQ_A_UNL2};
                        cyc.data = {8'h00, `FSQ_D_UNL2};
                    end
                    3'd2: begin
                        case (req_q.op)
                            FSQ_OP_PROG: cyc.data = {8'h00, `FSQ_D_PROG};
                            FSQ_OP_SECQ: cyc.data = {8'h00, `FSQ_D_SECQ};
                            FSQ_OP_UIDP: cyc.data = {8'h00, `FSQ_D_UIDP};
                            FSQ_OP_LOCK: cyc.data = {8'h00, `FSQ_D_LOCK};
                            FSQ_OP_EXIT: cyc.data = {8'h00, `FSQ_D_EXIT};
                            FSQ_OP_IDEN: begin
                                cyc.addr = {2'b00, req_q.addr[17:11], `FSQ_A_UNL1};
                                cyc.data = {8'h00, `FSQ_D_IDEN};
                            end
                            FSQ_OP_CFI: begin
                                cyc.addr = {2'b00, req_q.addr[17:11], `FSQ_A_UNL1};
                                cyc.data = {8'h00, `FSQ_D_CFI};
                            end
                            default: cyc.data = {8'h00, `FSQ_D_ERASE};
                        endcase
                    end
                    3'd3: begin
                        if (req_q.op == FSQ_OP_PROG || req_q.op == FSQ_OP_UIDP) begin
                            cyc.addr = req_q.addr;
                            cyc.addr_lsb = req_q.addr_lsb;
                            cyc.data = req_q.data;
                            is_data = 1'b1;
                        end else if (req_q.op == FSQ_OP_LOCK) begin
                            cyc.addr = req_q.addr;
                            cyc.data = 16'h0000;
                        end else begin
                            cyc.data = {8'h00, `FSQ_D_UNL1};
                        end
                    end
                    3'd4: begin
                        cyc.addr = {9'h000, `FSQ_A_UNL2};
                        cyc.data = {8'h00, `FSQ_D_UNL2};
                    end
                    default: begin
                        if (req_q.op == FSQ_OP_SECT) begin
                            cyc.addr = {req_q.addr[19:11], 11'h000};
                            cyc.data = {8'h00, `FSQ_D_SECT};
                        end else if (req_q.op == FSQ_OP_BLK) begin
                            cyc.addr = {req_q.addr[19:15], 15'h0000};
                            cyc.data = {8'h00, `FSQ_D_BLK};
                        end else begin
                            cyc.data = {8'h00, `FSQ_D_CHIP};
                        end
                    end
                endcase
            end
        endcase
    end

    // user identifier writes only inside the user word window
    assign uid_bad = i_req.op == FSQ_OP_UIDP &&
        (i_req.addr < `FSQ_UID_LO || i_req.addr > `FSQ_UID_HI);
    assign last = step_q == nsteps - 3'd1;
    assign start = st_q == H_ISSUE;
    assign o_req_ready = st_q == H_IDLE;

    always_comb begin
        st_d = st_q;
        req_d = req_q;
        step_d = step_q;
        mode_d = mode_q;
        rsp_d = 1'b0;
        err_d = err_q;
        rdata_d = rdata_q;
        case (st_q)
            H_IDLE: begin
                if (i_req_valid) begin
                    if (uid_bad) begin
                        rsp_d = 1'b1;
                        err_d = 1'b1;
                    end else begin
                        req_d = i_req;
                        step_d = 3'd0;
                        err_d = 1'b0;
                        st_d = H_ISSUE;
                    end
                end
            end
            H_ISSUE: begin
                st_d = H_WAIT;
            end
            H_WAIT: begin
                if (bus_done) begin
                    if (req_q.op == FSQ_OP_READ) begin
                        rdata_d = bus_rdata;
                    end
                    if (last) begin
                        rsp_d = 1'b1;
                        st_d = H_IDLE;
                        case (req_q.op)
                            FSQ_OP_IDEN: mode_d = FSQ_MODE_ID;
                            FSQ_OP_CFI: mode_d = FSQ_MODE_CFI;
                            FSQ_OP_SECQ: mode_d = FSQ_MODE_SECID;
                            FSQ_OP_EXIT: mode_d = FSQ_MODE_ARRAY;
                            FSQ_OP_UIDP, FSQ_OP_LOCK: mode_d = FSQ_MODE_ARRAY;
                            default: mode_d = mode_q;
                        endcase
                    end else begin
                        step_d = step_q + 3'd1;
                        st_d = H_ISSUE;
                    end
                end
            end
            default: begin
                st_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= H_IDLE;
            req_q <= '0;
            step_q <= 3'd0;
            mode_q <= FSQ_MODE_ARRAY;
            rsp_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            step_q <= step_d;
            mode_q <= mode_d;
            rsp_q <= rsp_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rsp_valid = rsp_q;
    assign o_rsp_err = err_q;
    assign o_rdata = rdata_q;
    assign o_mode = mode_q;

    fsq_bus u_bus (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .i_cyc(cyc),
        .i_dq(i_dq),
        .o_done(bus_done),
        .o_rdata(bus_rdata),
        .o_pins(o_pins)
    );

    property p_unlock;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && nsteps > 3'd1 && step_q == 3'd0 |->
            cyc.addr == 20'h00555 && cyc.data == 16'h00AA && !cyc.rd;
    endproperty
    a_unlock: assert property (p_unlock) else $error("first unlock write wrong");
    property p_cmd_low;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && !is_data |-> cyc.data[15:8] == 8'h00 && !cyc.addr_lsb;
    endproperty
    a_cmd_low: assert property (p_cmd_low) else $error("command upper byte not low");
    property p_sect;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && req_q.op == FSQ_OP_SECT && step_q == 3'd5 |->
            cyc.data == 16'h0030 && cyc.addr[10:0] == 11'h000;
    endproperty
    a_sect: assert property (p_sect) else $error("sector erase final write wrong");
    property p_chip;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && req_q.op == FSQ_OP_CHIP && step_q == 3'd5 |->
            cyc.addr == 20'h00555 && cyc.data == 16'h0010;
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase final write wrong");
    property p_susp;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && req_q.op == FSQ_OP_SUSP |-> cyc.data == 16'h00B0 && last;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not a single B0 write");
    property p_lock;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && req_q.op == FSQ_OP_LOCK |-> cyc.byte_n;
    endproperty
    a_lock: assert property (p_lock) else $error("lock-out not in word mode");
    property p_id_bank;
        @(posedge i_mclk) disable iff (!i_rst_n)
        start && req_q.op == FSQ_OP_IDEN && step_q == 3'd2 |->
            cyc.addr[19:18] == 2'b00 && cyc.data == 16'h0090;
    endproperty
    a_id_bank: assert property (p_id_bank) else $error("identification entry wrong");
    property p_exit;
        @(posedge i_mclk) disable iff (!i_rst_n)
        st_q == H_WAIT && bus_done && last && req_q.op == FSQ_OP_EXIT |=>
            mode_q == FSQ_MODE_ARRAY && o_rsp_valid;
    endproperty
    a_exit: assert property (p_exit) else $error("exit did not restore array mode");
    property p_uid_ref;
        @(posedge i_mclk) disable iff (!i_rst_n)
        st_q == H_IDLE && i_req_valid && uid_bad |=>
            o_rsp_valid && o_rsp_err && st_q == H_IDLE;
    endproperty
    a_uid_ref: assert property (p_uid_ref) else $error("bad identifier address taken");
endmodule

// ===== hdl/fsq_regs.svh
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH
// timing, in ns, and derived cycle counts
`define FSQ_CLK_NS 50
`define FSQ_T_SU_NS 50
`define FSQ_T_WP_NS 100
`define FSQ_T_ACC_NS 100
`define FSQ_SU_CYC ((`FSQ_T_SU_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_WP_CYC ((`FSQ_T_WP_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_ACC_CYC ((`FSQ_T_ACC_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
// extra strobe cycles that cover the data pin synchroniser
`define FSQ_SYNC_CYC 2
// command addresses and codes
`define FSQ_A_UNL1 11'h555
`define FSQ_A_UNL2 11'h2AA
`define FSQ_D_UNL1 8'hAA
`define FSQ_D_UNL2 8'h55
`define FSQ_D_PROG 8'hA0
`define FSQ_D_ERASE 8'h80
`define FSQ_D_SECT 8'h30
`define FSQ_D_BLK 8'h50
`define FSQ_D_CHIP 8'h10
`define FSQ_D_SUSP 8'hB0
`define FSQ_D_RES 8'h30
`define FSQ_D_SECQ 8'h88
`define FSQ_D_UIDP 8'hA5
`define FSQ_D_LOCK 8'h85
`define FSQ_D_IDEN 8'h90
`define FSQ_D_CFI 8'h98
`define FSQ_D_EXIT 8'hF0
// user identifier word window
`define FSQ_UID_LO 20'h00010
`define FSQ_UID_HI 20'h00017
`endif

// ===== hdl/fsq_pkg.sv
package fsq_pkg;
    typedef enum logic [3:0] {
        FSQ_OP_READ, FSQ_OP_PROG, FSQ_OP_SECT, FSQ_OP_BLK, FSQ_OP_CHIP,
        FSQ_OP_SUSP, FSQ_OP_RES, FSQ_OP_SECQ, FSQ_OP_UIDP, FSQ_OP_LOCK,
        FSQ_OP_IDEN, FSQ_OP_CFI, FSQ_OP_EXIT
    } fsq_op_e;
    typedef enum logic [1:0] {
        FSQ_MODE_ARRAY, FSQ_MODE_ID, FSQ_MODE_CFI, FSQ_MODE_SECID
    } fsq_mode_e;
    typedef struct packed {
        fsq_op_e op;
        logic [19:0] addr;
        logic addr_lsb;
        logic [15:0] data;
        logic byte_mode;
    } fsq_req_s;
    typedef struct packed {
        logic rd;
        logic [19:0] addr;
        logic addr_lsb;
        logic [15:0] data;
        logic byte_n;
    } fsq_cyc_s;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
        logic [19:0] addr;
        logic addr_lsb;
        logic [15:0] dq_o;
        logic dq_oe;
    } fsq_pins_s;
endpackage

// ===== hdl/fsq_bus.sv
`timescale 1ns/1ps
`include "fsq_regs.svh"
module fsq_bus import fsq_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire fsq_cyc_s i_cyc,
    input wire logic [15:0] i_dq,
    output logic o_done,
    output logic [15:0] o_rdata,
    output fsq_pins_s o_pins
);
    localparam logic [2:0] SU = 3'(`FSQ_SU_CYC);
    localparam logic [2:0] WP = 3'(`FSQ_WP_CYC);
    localparam logic [2:0] RD = 3'(`FSQ_ACC_CYC + `FSQ_SYNC_CYC);
    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fsq_bst_e;
    fsq_bst_e st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic rd_q, rd_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    fsq_pins_s pins_q, pins_d;
    logic [15:0] dq_s1_q, dq_s2_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= i_dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        pins_d = pins_q;
        case (st_q)
            B_IDLE: begin
                if (i_start) begin
                    pins_d.ce_n = 1'b0;
                    pins_d.byte_n = i_cyc.byte_n;
                    pins_d.addr = i_cyc.addr;
                    pins_d.addr_lsb = i_cyc.addr_lsb;
                    pins_d.dq_o = i_cyc.data;
                    pins_d.dq_oe = !i_cyc.rd;
                    rd_d = i_cyc.rd;
                    cnt_d = SU - 3'h1;
                    st_d = B_SETUP;
                end
            end
            B_SETUP: begin
                if (cnt_q == 3'h0) begin
                    pins_d.we_n = rd_q;
                    pins_d.oe_n = !rd_q;
                    cnt_d = (rd_q ? RD : WP) - 3'h1;
                    st_d = B_STROBE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            B_STROBE: begin
                if (cnt_q == 3'h0) begin
                    if (rd_q) begin
                        rdata_d = dq_s2_q;
                    end
                    pins_d.we_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    st_d = B_HOLD;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            B_HOLD: begin
                pins_d.ce_n = 1'b1;
                pins_d.dq_oe = 1'b0;
                done_d = 1'b1;
                st_d = B_IDLE;
            end
            default: begin
                st_d = B_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= B_IDLE;
            cnt_q <= 3'h0;
            rd_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, byte_n: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            pins_q <= pins_d;
        end
    end

    assign o_done = done_q;
    assign o_rdata = rdata_q;
    assign o_pins = pins_q;

    property p_we_width;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $fell(pins_q.we_n) |-> !pins_q.we_n [*2] ##1 pins_q.we_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_we_in_ce;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !pins_q.we_n |-> !pins_q.ce_n && pins_q.oe_n && pins_q.dq_oe;
    endproperty
    a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside select");
endmodule

// ===== test/fsq_flash_model.sv
`timescale 1ns/1ps
module fsq_flash_model import fsq_pkg::*; #(
    parameter logic [15:0] MFR_CODE = 16'h00C3, // arbitrary
    parameter logic [15:0] DEV_CODE = 16'h2D71 // arbitrary
) (
    input wire fsq_pins_s i_pins,
    output logic [15:0] o_dq
);
    logic [15:0] mem [int];
    logic [15:0] uid [8] = '{default: 16'hFFFF};
    logic [19:0] log_a [$];
    logic [15:0] log_d [$];
    logic log_b [$];
    fsq_mode_e mode_q = FSQ_MODE_ARRAY;
    logic locked = 1'b0;
    logic susp = 1'b0;
    int step = 0;
    logic [7:0] cmd = 8'h00;
    logic [15:0] rd_v;
    logic [15:0] last = 16'h0000;
    function automatic logic [15:0] rdm(input logic [19:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction
    task automatic wipe(input logic [19:0] a, input logic [19:0] m);
        int ks[$];
        foreach (mem[k]) begin
            if ((20'(k) & m) == (a & m)) ks.push_back(k);
        end
        foreach (ks[j]) mem.delete(ks[j]);
    endtask
    // decode one write strobe
    task automatic take(input logic [19:0] a, input logic [15:0] dw);
        logic [7:0] d;
        logic hit;
        d = dw[7:0];
        hit = a[10:0] == 11'h555;
        case (step)
            0: begin
                if (hit && d == 8'hAA) step = 1;
                else if (d == 8'hB0) susp = 1'b1;
                else if (d == 8'h30) susp = 1'b0;
            end
            1, 4: step = (a[10:0] == 11'h2AA && d == 8'h55) ? step + 1 : 0;
            2: begin
                step = 0;
                cmd = (hit || d == 8'h90 || d == 8'h98) ? d : 8'h00;
                if (cmd == 8'h88) mode_q = FSQ_MODE_SECID;
                if (cmd == 8'h90 && a[19:18] == 2'b00) mode_q = FSQ_MODE_ID;
                if (cmd == 8'h98) mode_q = FSQ_MODE_CFI;
                if (cmd == 8'hF0) mode_q = FSQ_MODE_ARRAY;
                if (cmd inside {8'hA0, 8'hA5, 8'h85, 8'h80}) step = 3;
            end
            3: begin
                step = (cmd == 8'h80 && hit && d == 8'hAA) ? 4 : 0;
                if (cmd == 8'hA0) mem[int'(a)] = rdm(a) & (i_pins.byte_n ? dw : {8'hFF, d});
                if (cmd == 8'hA5 && !locked && a >= 20'h00010 && a <= 20'h00017) uid[a[2:0]] &= dw;
                if (cmd == 8'h85 && dw == 16'h0000 && i_pins.byte_n) locked = 1'b1;
                if (cmd inside {8'hA5, 8'h85}) mode_q = FSQ_MODE_ARRAY;
            end
            default: begin
                step = 0;
                if (d == 8'h30) wipe(a, 20'hFF800);
                if (d == 8'h50) wipe(a, 20'hF8000);
                if (d == 8'h10 && hit) wipe(a, 20'h00000);
            end
        endcase
    endtask
    always @(i_pins or mode_q or locked) begin
        case (mode_q)
            FSQ_MODE_ID: rd_v = i_pins.addr[0] ? DEV_CODE : MFR_CODE;
            FSQ_MODE_CFI: rd_v = 16'h0C00 | 16'(i_pins.addr[7:0]);
            FSQ_MODE_SECID: rd_v = (i_pins.addr[7:0] == 8'hFF) ? {12'h000, !locked, 3'h0} :
                i_pins.addr[4] ? uid[i_pins.addr[2:0]] : 16'hF000 | 16'(i_pins.addr[2:0]);
            default: rd_v = rdm(i_pins.addr);
        endcase
    end
    always @(posedge i_pins.we_n) begin
        if (!i_pins.ce_n) begin
            log_a.push_back(i_pins.addr);
            log_d.push_back(i_pins.dq_o);
            log_b.push_back(i_pins.byte_n);
            take(i_pins.addr, i_pins.dq_o);
        end
    end
    always @(posedge i_pins.oe_n) begin
        if (!i_pins.ce_n) last = rd_v;
    end
    // released bus shows the inverse of the last value
    assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? rd_v : ~last;
endmodule

// ===== test/fsq_host_tb.sv
`timescale 1ns/1ps
module fsq_host_tb import fsq_pkg::*;;
    localparam logic [15:0] MFR = 16'h00C3; // arbitrary
    localparam logic [15:0] DEV = 16'h2D71; // arbitrary
    logic i_mclk, i_rst_n, i_req_valid, req_ready, rsp_valid, rsp_err, err;
    fsq_req_s i_req;
    logic [15:0] rdata, dq, rd;
    fsq_mode_e mode;
    fsq_pins_s pins;
    int n_fail = 0;
    int checks = 0;
    int base = 0;
    logic [19:0] ea[$], em[$];
    logic [7:0] ed[$];
    fsq_host i_fsq_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err), .o_rdata(rdata),
        .o_mode(mode), .i_dq(dq), .o_pins(pins));
    fsq_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_fsq_flash_model (.i_pins(pins), .o_dq(dq));
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s: %0h vs %0h", $time, what, seen, exp);
        end
    endtask
    task automatic tmo();
        n_fail++;
        $display("ERROR %0t timeout", $time);
        tally_and_finish();
    endtask
    task automatic ex(input logic [19:0] a, input logic [7:0] d, input logic [19:0] m);
        ea.push_back(a);
        ed.push_back(d);
        em.push_back(m);
    endtask
    task automatic unl();
        ex(20'h00555, 8'hAA, 20'h007FF);
        ex(20'h002AA, 8'h55, 20'h007FF);
    endtask
    // one request, held until taken, then wait for its answer
    task automatic run(input fsq_op_e op, input logic [19:0] a, input logic [15:0] d, input logic bm);
        int k;
        base = i_fsq_flash_model.log_a.size();
        @(posedge i_mclk);
        #2;
        i_req = '{op, a, bm, d, bm};
        i_req_valid = 1'b1;
        for (k = 0; req_ready !== 1'b1; k++) begin
            if (k == 50) tmo();
            @(posedge i_mclk);
            #2;
        end
        @(posedge i_mclk);
        #2;
        i_req_valid = 1'b0;
        for (k = 0; rsp_valid !== 1'b1; k++) begin
            if (k == 400) tmo();
            @(posedge i_mclk);
            #2;
        end
        err = rsp_err;
        rd = rdata;
    endtask
    // compare logged strobes with the expected list
    task automatic vw();
        int n;
        n = i_fsq_flash_model.log_a.size() - base;
        check(20'(n), 20'(ea.size()), "writes");
        foreach (ea[i]) begin
            if (i < n) begin
                check(i_fsq_flash_model.log_a[base + i] & em[i], ea[i] & em[i], "addr");
                check(20'(i_fsq_flash_model.log_d[base + i][7:0]), 20'(ed[i]), "data");
            end
        end
        ea.delete();
        ed.delete();
        em.delete();
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [15:0] e);
        run(FSQ_OP_READ, a, 16'h0000, 1'b0);
        check(20'(rd), 20'(e), "read");
    endtask
    task automatic t_reset();
        check(20'(mode), 20'(FSQ_MODE_ARRAY), "mode");
        check(20'({pins.ce_n, pins.we_n, pins.dq_oe}), 20'h6, "idle pins");
    endtask
    task automatic t_program();
        unl();
        ex(20'h00555, 8'hA0, 20'h007FF);
        ex(20'h2A812, 8'h5A, 20'hFFFFF);
        run(FSQ_OP_PROG, 20'h2A812, 16'h125A, 1'b0);
        vw();
        rd_chk(20'h2A812, 16'h125A);
        unl();
        ex(20'h00555, 8'hA0, 20'h007FF);
        ex(20'h00200, 8'h33, 20'hFFFFF);
        run(FSQ_OP_PROG, 20'h00200, 16'h0033, 1'b1);
        vw();
        check(20'({i_fsq_flash_model.log_b[$], pins.addr_lsb}), 20'h1, "byte pin");
    endtask
    task automatic t_erase();
        fsq_op_e ops[3] = '{FSQ_OP_SECT, FSQ_OP_BLK, FSQ_OP_CHIP};
        logic [7:0] cd[3] = '{8'h30, 8'h50, 8'h10};
        logic [19:0] mk[3] = '{20'hFF800, 20'hF8000, 20'h007FF};
        for (int i = 0; i < 3; i++) begin
            unl();
            ex(20'h00555, 8'h80, 20'h007FF);
            unl();
            ex(i == 2 ? 20'h00555 : 20'h2A800, cd[i], mk[i]);
            run(ops[i], 20'h2A800, 16'h0000, 1'b0);
            vw();
            if (i == 0) rd_chk(20'h2A812, 16'hFFFF);
        end
        ex(20'h2A800, 8'hB0, 20'h00000);
        run(FSQ_OP_SUSP, 20'h2A800, 16'h0000, 1'b0);
        vw();
        check(20'(i_fsq_flash_model.susp), 20'h1, "suspend");
        ex(20'h2A800, 8'h30, 20'h00000);
        run(FSQ_OP_RES, 20'h2A800, 16'h0000, 1'b0);
        vw();
        check(20'(i_fsq_flash_model.susp), 20'h0, "resume");
    endtask
    task automatic sec_entry();
        unl();
        ex(20'h00555, 8'h88, 20'h007FF);
        run(FSQ_OP_SECQ, 20'h00000, 16'h0000, 1'b0);
        vw();
        check(20'(mode), 20'(FSQ_MODE_SECID), "mode");
    endtask
    task automatic t_uid();
        sec_entry();
        rd_chk(20'h00003, 16'hF003);
        rd_chk(20'h00013, 16'hFFFF);
        rd_chk(20'h000FF, 16'h0008);
        for (int i = 0; i < 2; i++) begin
            unl();
            ex(20'h00555, 8'hA5, 20'h007FF);
            ex(20'h00017, i ? 8'hFF : 8'h0F, 20'hFFFFF);
            run(FSQ_OP_UIDP, 20'h00017, i ? 16'hF0FF : 16'hFF0F, 1'b0);
            vw();
            check(20'(mode), 20'(FSQ_MODE_ARRAY), "mode");
        end
        run(FSQ_OP_UIDP, 20'h00018, 16'h0000, 1'b0);
        vw();
        check(20'(err), 20'h1, "refused");
        sec_entry();
        rd_chk(20'h00017, 16'hF00F);
        unl();
        ex(20'h00555, 8'h85, 20'h007FF);
        ex(20'h00000, 8'h00, 20'h00000);
        run(FSQ_OP_LOCK, 20'h00000, 16'h0000, 1'b1);
        vw();
        check({i_fsq_flash_model.log_b[$], 3'h0, i_fsq_flash_model.log_d[$]}, 20'h80000, "lock");
        sec_entry();
        rd_chk(20'h000FF, 16'h0000);
    endtask
    task automatic t_modes();
        fsq_op_e ops[2] = '{FSQ_OP_IDEN, FSQ_OP_CFI};
        fsq_mode_e md[2] = '{FSQ_MODE_ID, FSQ_MODE_CFI};
        logic [7:0] cd[2] = '{8'h90, 8'h98};
        for (int i = 0; i < 2; i++) begin
            unl();
            ex(20'h00555, cd[i], 20'hC07FF);
            run(ops[i], 20'h05000, 16'h0000, 1'b0);
            vw();
            check(20'(mode), 20'(md[i]), "mode");
            rd_chk(20'h00000, i ? 16'h0C00 : MFR);
            rd_chk(20'h00001, i ? 16'h0C01 : DEV);
            unl();
            ex(20'h00555, 8'hF0, 20'h007FF);
            run(FSQ_OP_EXIT, 20'h00000, 16'h0000, 1'b0);
            vw();
            check(20'(mode), 20'(FSQ_MODE_ARRAY), "mode");
            rd_chk(20'h2A812, 16'hFFFF);
        end
    endtask
    // reset in mid-run drops the tracked mode back to array read
    task automatic t_rerun();
        sec_entry();
        @(posedge i_mclk);
        #2;
        i_rst_n = 1'b0;
        #1;
        t_reset();
        @(posedge i_mclk);
        #2;
        i_rst_n = 1'b1;
        rd_chk(20'h000FF, 16'h0000);
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        repeat (2) @(posedge i_mclk);
        #2;
        t_reset();
        i_rst_n = 1'b1;
        t_program();
        t_erase();
        t_uid();
        t_modes();
        t_rerun();
        tally_and_finish();
    end
endmodule
